// ---- rtl/touch_tag_pkg.sv ----
// Purpose: Shared constants and types of the touch tag reporting block
// Assumes: 32-bit AXI4-Lite register access, byte addresses below
// Notes:   Coordinates are 16 bits each, tags 8 bits
package touch_tag_pkg;

  localparam int unsigned POINT_COUNT = 5;
  localparam int unsigned COEFF_COUNT = 6;
  localparam int unsigned ADDR_BITS   = 12;

  localparam logic [11:0] OFS_XY0    = 12'h128;
  localparam logic [11:0] OFS_TAG0   = 12'h12C;
  localparam logic [11:0] OFS_XY1    = 12'h130;
  localparam logic [11:0] OFS_TAG1   = 12'h134;
  localparam logic [11:0] OFS_XY2    = 12'h138;
  localparam logic [11:0] OFS_TAG2   = 12'h13C;
  localparam logic [11:0] OFS_XY3    = 12'h140;
  localparam logic [11:0] OFS_TAG3   = 12'h144;
  localparam logic [11:0] OFS_XY4    = 12'h148;
  localparam logic [11:0] OFS_TAG4   = 12'h14C;
  localparam logic [11:0] OFS_CTRL   = 12'h150;
  localparam logic [11:0] OFS_STATUS = 12'h154;
  localparam logic [11:0] OFS_COEFF0 = 12'h158;
  localparam logic [11:0] COEFF_STEP = 12'h004;

  localparam int unsigned CTRL_EXT_BIT     = 0;
  localparam int unsigned CTRL_CAL_BIT     = 1;
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_REFUSED_BIT = 1;

  localparam logic [7:0]  TAG_NONE     = 8'h00;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic        touched;
    logic [7:0]  tag;
    logic [15:0] x;
    logic [15:0] y;
  } touch_point_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_BUSY = 2'b10
  } cal_state_t;

endpackage

// ---- rtl/touch_tag_report.sv ----
// Purpose: Per-frame touch tag and lookup coordinate reporting with AXI4-Lite access
// Assumes: Touch engine inputs are synchronous to aclk; frame_end pulses once per frame
// Notes:   Calibration is started here and its coefficients are captured on completion
`timescale 1ns/100ps

module touch_tag_report
  import touch_tag_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_BITS
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output      logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output      logic                          s_axi_wready,
  output      logic [1:0]                    s_axi_bresp,
  output      logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output      logic                          s_axi_arready,
  output      logic [31:0]                   s_axi_rdata,
  output      logic [1:0]                    s_axi_rresp,
  output      logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          frame_end,
  input  wire touch_point_t [POINT_COUNT-1:0] sample,
  output      logic                          extended_mode,
  output      logic                          calib_start,
  input  wire logic                          calib_done,
  input  wire logic [COEFF_COUNT-1:0][31:0]  calib_coeff,
  output      logic [COEFF_COUNT-1:0][31:0]  touch_coefficient_set
);

  if (ADDR_W < 9 || ADDR_W > 12) begin : g_bad_addr_w
    $error("ADDR_W must lie between 9 and 12");
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [11:0] word_addr(input logic [ADDR_W-1:0] a);
    logic [11:0] wide;
    wide = 12'(a);
    return {wide[11:2], 2'b00};
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    if (a >= OFS_XY0 && a <= OFS_STATUS) begin
      return 1'b1;
    end else if (a >= OFS_COEFF0 && a < OFS_COEFF0 + 12'(COEFF_COUNT * 4)) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  logic [POINT_COUNT-1:0][7:0]  object_id;
  logic [POINT_COUNT-1:0][31:0] lookup_xy;
  logic                         refused;
  cal_state_t                   cal_state;
  cal_state_t                   next_cal_state;
  logic [11:0]                  wr_addr;
  logic [31:0]                  wr_data;
  logic [3:0]                   wr_strb;

  // Extra points report nothing in compatibility mode
  logic [POINT_COUNT-1:0] point_live;
  assign point_live[0] = 1'b1;
  assign point_live[POINT_COUNT-1:1] = {(POINT_COUNT-1){extended_mode}};

  logic [POINT_COUNT-1:0][7:0]  next_object_id;
  logic [POINT_COUNT-1:0][31:0] next_lookup_xy;
  for (genvar p = 0; p < POINT_COUNT; p++) begin : g_point
    assign next_object_id[p] = (point_live[p] && sample[p].touched) ? sample[p].tag : TAG_NONE;
    assign next_lookup_xy[p] = point_live[p] ? {sample[p].x, sample[p].y} : REG_RESET;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      object_id <= '0;
      lookup_xy <= '0;
    end else if (frame_end) begin
      object_id <= next_object_id;
      lookup_xy <= next_lookup_xy;
    end
  end

  // Write channel: address and data are held until both are present
  wire aw_fire  = s_axi_awvalid && s_axi_awready;
  wire w_fire   = s_axi_wvalid && s_axi_wready;
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_hit   = addr_mapped(wr_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_addr       <= 12'h000;
      wr_data       <= REG_RESET;
      wr_strb       <= 4'h0;
    end else begin
      if (aw_fire) begin
        wr_addr       <= word_addr(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Only control and status take writes; all reporting registers stay read-only
  wire ctrl_wr     = do_write && wr_addr == OFS_CTRL && wr_strb[0];
  wire status_wr   = do_write && wr_addr == OFS_STATUS && wr_strb[0];
  wire cal_request = ctrl_wr && wr_data[CTRL_CAL_BIT];
  // The mode in force before the write decides whether calibration may start
  wire cal_accept  = cal_request && !extended_mode && cal_state == CAL_IDLE;
  wire cal_deny    = cal_request && !cal_accept;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extended_mode <= 1'b0;
    end else if (ctrl_wr) begin
      extended_mode <= wr_data[CTRL_EXT_BIT];
    end
  end

  always_comb begin
    next_cal_state = cal_state;
    case (cal_state)
      CAL_IDLE: begin
        if (cal_accept) begin
          next_cal_state = CAL_BUSY;
        end
      end
      CAL_BUSY: begin
        if (calib_done) begin
          next_cal_state = CAL_IDLE;
        end
      end
      default: begin
        next_cal_state = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_state   <= CAL_IDLE;
      calib_start <= 1'b0;
    end else begin
      cal_state   <= next_cal_state;
      calib_start <= cal_accept;
    end
  end

  // Refusal flag: a new refusal wins over a simultaneous write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused <= 1'b0;
    end else if (cal_deny) begin
      refused <= 1'b1;
    end else if (status_wr && wr_data[STAT_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  // Coefficients are taken on completion whatever the mode, and feed the engine in both modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      touch_coefficient_set <= '0;
    end else if (calib_done) begin
      touch_coefficient_set <= calib_coeff;
    end
  end

  // Read channel: one read outstanding, data registered one cycle after the address
  wire [11:0] rd_addr  = word_addr(s_axi_araddr);
  wire        rd_hit   = addr_mapped(rd_addr);
  wire [11:0] coeff_of = rd_addr - OFS_COEFF0;
  wire [2:0]  coeff_ix = coeff_of[4:2];
  wire        in_coeff = rd_addr >= OFS_COEFF0;
  wire        in_point = rd_addr < OFS_CTRL;
  wire [11:0] pt_of    = rd_addr - OFS_XY0;
  wire [2:0]  pt_ix    = pt_of[5:3];
  wire        pt_tag   = pt_of[2];
  wire [31:0] status_word = {30'h0000_0000, refused, cal_state == CAL_BUSY};
  wire [31:0] ctrl_word   = {31'h0000_0000, extended_mode};

  logic [31:0] rd_word;
  always_comb begin
    rd_word = REG_RESET;
    if (!rd_hit) begin
      rd_word = REG_RESET;
    end else if (in_coeff) begin
      rd_word = touch_coefficient_set[coeff_ix];
    end else if (in_point && pt_tag) begin
      rd_word = {24'h00_0000, object_id[pt_ix]};
    end else if (in_point) begin
      rd_word = lookup_xy[pt_ix];
    end else if (rd_addr == OFS_CTRL) begin
      rd_word = ctrl_word;
    end else begin
      rd_word = status_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= REG_RESET;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  tag_hold_a: assert property (
    !frame_end |=> $stable(object_id) && $stable(lookup_xy)
  ) else $error("touch report changed outside frame end");

  fifth_tag_a: assert property (
    frame_end && extended_mode |=>
      object_id[4] == ($past(sample[4].touched) ? $past(sample[4].tag) : TAG_NONE)
  ) else $error("fifth point tag not latched in extended mode");

  no_touch_a: assert property (
    frame_end && !sample[0].touched |=> object_id[0] == TAG_NONE
  ) else $error("absent touch not reported as zero");

  reset_zero_a: assert property (
    $past(!aresetn) |-> object_id == '0 && lookup_xy == '0
  ) else $error("report registers not zero after reset");

  compat_blank_a: assert property (
    frame_end && !extended_mode |=> object_id[4:1] == '0 ##1 object_id[4:1] == '0 || $past(frame_end)
  ) else $error("extra point tag reported in compatibility mode");

  xy_fields_a: assert property (
    frame_end |=> lookup_xy[0][31:16] == $past(sample[0].x) && lookup_xy[0][15:0] == $past(sample[0].y)
  ) else $error("first point coordinates misplaced");

  y_field_a: assert property (
    frame_end && extended_mode |=> lookup_xy[2][15:0] == $past(sample[2].y)
  ) else $error("third point Y coordinate misplaced");

  xy_readonly_a: assert property (
    do_write && !frame_end |=> $stable(lookup_xy)
  ) else $error("host write altered coordinates");

  pair_match_a: assert property (
    frame_end && extended_mode && sample[3].touched |=>
      object_id[3] == $past(sample[3].tag) && lookup_xy[3] == {$past(sample[3].x), $past(sample[3].y)}
  ) else $error("fourth point tag and coordinates disagree");

  cal_refuse_a: assert property (
    cal_request && extended_mode |=> !calib_start && refused
  ) else $error("calibration started in extended mode");

  cal_start_a: assert property (
    cal_request && !extended_mode && cal_state == CAL_IDLE |=> calib_start ##1 !calib_start
  ) else $error("calibration start not a single pulse");

  coeff_load_a: assert property (
    calib_done |=> touch_coefficient_set == $past(calib_coeff)
  ) else $error("coefficients not captured on completion");

  coeff_mode_a: assert property (
    !calib_done && $changed(extended_mode) |=> $stable(touch_coefficient_set)
  ) else $error("mode change disturbed coefficients");

  first_tag_a: assert property (
    frame_end && sample[0].touched |=> object_id[0] == $past(sample[0].tag)
  ) else $error("first point tag not reported");

  xy_read_a: assert property (
    s_axi_arvalid && s_axi_arready && rd_addr == OFS_XY0 |=> s_axi_rvalid && s_axi_rdata == $past(lookup_xy[0])
  ) else $error("coordinate register read mismatch");

  tag_field_a: assert property (
    s_axi_arvalid && s_axi_arready && rd_hit && in_point && pt_tag |=> s_axi_rdata[31:8] == 24'h00_0000
  ) else $error("reserved tag bits not zero");

  compat_xy_a: assert property (
    frame_end && !extended_mode |=> lookup_xy[4:1] == '0
  ) else $error("extra point coordinates reported in compatibility mode");

  ro_resp_a: assert property (
    do_write && wr_addr == OFS_XY0 |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY
  ) else $error("coordinate register write not answered as ignored");

  refuse_wins_a: assert property (
    cal_deny |=> refused
  ) else $error("calibration refusal not flagged");

  cal_busy_a: assert property (
    cal_accept |=> cal_state == CAL_BUSY
  ) else $error("accepted calibration not marked busy");

  busy_end_a: assert property (
    calib_done && !cal_accept |=> cal_state == CAL_IDLE
  ) else $error("calibration still busy after completion");

  rd_unmapped_a: assert property (
    s_axi_arvalid && s_axi_arready && !rd_hit |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == REG_RESET
  ) else $error("unmapped read not refused");

endmodule

// ---- dv/test_touch_tag_report.sv ----
// Purpose: Self-checking bench for the touch tag reporting block
// Assumes: Bus tasks are entered just after a rising edge of aclk
// Notes:   Expected values come from a small model kept in this bench
`timescale 1ns/100ps

module test_touch_tag_report
  import touch_tag_pkg::*;
;
  logic                           aclk = 1'b0;
  logic                           aresetn = 1'b0;
  logic [11:0]                    s_axi_awaddr = 12'h000;
  logic                           s_axi_awvalid = 1'b0;
  logic                           s_axi_awready;
  logic [31:0]                    s_axi_wdata = 32'h0;
  logic [3:0]                     s_axi_wstrb = 4'hF;
  logic                           s_axi_wvalid = 1'b0;
  logic                           s_axi_wready;
  logic [1:0]                     s_axi_bresp;
  logic                           s_axi_bvalid;
  // Both response readies stay high for the whole run
  logic                           s_axi_bready = 1'b1;
  logic [11:0]                    s_axi_araddr = 12'h000;
  logic                           s_axi_arvalid = 1'b0;
  logic                           s_axi_arready;
  logic [31:0]                    s_axi_rdata;
  logic [1:0]                     s_axi_rresp;
  logic                           s_axi_rvalid;
  logic                           s_axi_rready = 1'b1;
  logic                           frame_end = 1'b0;
  touch_point_t [POINT_COUNT-1:0] sample = '0;
  logic                           extended_mode;
  logic                           calib_start;
  logic                           calib_done = 1'b0;
  logic [COEFF_COUNT-1:0][31:0]   calib_coeff = '0;
  logic [COEFF_COUNT-1:0][31:0]   touch_coefficient_set;
  int                             errors = 0;
  int                             num_checks = 0;
  int                             cycles = 0;
  int                             cal_pulses = 0;
  bit                             ext_m = 0;
  logic [7:0]                     exp_tag[POINT_COUNT];
  logic [31:0]                    exp_xy[POINT_COUNT];
  bit                             xy_known[POINT_COUNT];
  logic [31:0]                    exp_coeff[COEFF_COUNT];
  logic [11:0]                    tag_ofs[POINT_COUNT] = '{OFS_TAG0, OFS_TAG1, OFS_TAG2, OFS_TAG3, OFS_TAG4};
  logic [11:0]                    xy_ofs[POINT_COUNT] = '{OFS_XY0, OFS_XY1, OFS_XY2, OFS_XY3, OFS_XY4};
  logic [31:0]                    rd;
  logic [1:0]                     rsp;

  touch_tag_report touch_tag_report_inst (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .s_axi_awaddr          (s_axi_awaddr),
    .s_axi_awvalid         (s_axi_awvalid),
    .s_axi_awready         (s_axi_awready),
    .s_axi_wdata           (s_axi_wdata),
    .s_axi_wstrb           (s_axi_wstrb),
    .s_axi_wvalid          (s_axi_wvalid),
    .s_axi_wready          (s_axi_wready),
    .s_axi_bresp           (s_axi_bresp),
    .s_axi_bvalid          (s_axi_bvalid),
    .s_axi_bready          (s_axi_bready),
    .s_axi_araddr          (s_axi_araddr),
    .s_axi_arvalid         (s_axi_arvalid),
    .s_axi_arready         (s_axi_arready),
    .s_axi_rdata           (s_axi_rdata),
    .s_axi_rresp           (s_axi_rresp),
    .s_axi_rvalid          (s_axi_rvalid),
    .s_axi_rready          (s_axi_rready),
    .frame_end             (frame_end),
    .sample                (sample),
    .extended_mode         (extended_mode),
    .calib_start           (calib_start),
    .calib_done            (calib_done),
    .calib_coeff           (calib_coeff),
    .touch_coefficient_set (touch_coefficient_set)
  );

  always #2 aclk = ~aclk;

  // Counted on the falling edge, where the pulse has settled
  always @(negedge aclk) begin
    if (calib_start === 1'b1) cal_pulses++;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d num_checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // New samples each call; the model only follows them when a frame ends
  task automatic frame(input bit pulse);
    touch_point_t p;
    bit act;
    for (int i = 0; i < POINT_COUNT; i++) begin
      p.touched = ($urandom % 4) != 0;
      p.tag = 8'(1 + $urandom % 255);
      p.x = 16'($urandom);
      p.y = 16'($urandom);
      sample[i] <= p;
      act = ext_m || i == 0;
      if (pulse) begin
        exp_tag[i] = (act && p.touched) ? p.tag : TAG_NONE;
        exp_xy[i] = act ? {p.x, p.y} : 32'h0;
        xy_known[i] = !act || p.touched;
      end
    end
    frame_end <= pulse;
    @(posedge aclk);
    frame_end <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic check_all();
    for (int i = 0; i < POINT_COUNT; i++) begin
      axi_read(tag_ofs[i], rd, rsp);
      chk(rd, {24'h0, exp_tag[i]});
      axi_read(xy_ofs[i], rd, rsp);
      if (xy_known[i]) chk(exp_xy[i], rd);
    end
  endtask

  task automatic check_coeff();
    for (int k = 0; k < COEFF_COUNT; k++) begin
      axi_read(12'(OFS_COEFF0 + 4 * k), rd, rsp);
      chk(rd, exp_coeff[k]);
      chk(touch_coefficient_set[k], exp_coeff[k]);
    end
  endtask

  // Model state as it must stand after any reset
  task automatic model_clear();
    ext_m = 0;
    for (int i = 0; i < POINT_COUNT; i++) begin
      exp_tag[i] = TAG_NONE;
      exp_xy[i] = 32'h0;
      xy_known[i] = 1;
    end
    for (int k = 0; k < COEFF_COUNT; k++) begin
      exp_coeff[k] = 32'h0;
    end
  endtask

  initial begin
    void'($urandom(9378));
    model_clear();
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_all();
    check_coeff();
    repeat (3) begin
      frame(1);
      check_all();
    end
    frame(0);
    check_all();
    axi_write(OFS_XY0, 32'hFFFF_FFFF, rsp);
    chk(32'(rsp), 32'(RESP_OKAY));
    axi_write(OFS_TAG4, 32'h0000_00FF, rsp);
    check_all();
    axi_read(12'hFFC, rd, rsp);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    axi_write(12'hFFC, 32'h1, rsp);
    chk(32'(rsp), 32'(RESP_SLVERR));
    axi_write(OFS_CTRL, 32'h2, rsp);
    chk(cal_pulses, 1);
    axi_read(OFS_STATUS, rd, rsp);
    chk(rd, 32'h1);
    calib_done <= 1'b1;
    for (int k = 0; k < COEFF_COUNT; k++) begin
      exp_coeff[k] = $urandom;
      calib_coeff[k] <= exp_coeff[k];
    end
    @(posedge aclk);
    calib_done <= 1'b0;
    @(posedge aclk);
    check_coeff();
    axi_read(OFS_STATUS, rd, rsp);
    chk(rd, 32'h0);
    axi_write(OFS_CTRL, 32'h1, rsp);
    chk(32'(extended_mode), 32'h1);
    ext_m = 1;
    // Without the low byte strobe the control write must leave the mode alone
    s_axi_wstrb <= 4'hE;
    axi_write(OFS_CTRL, 32'h0, rsp);
    s_axi_wstrb <= 4'hF;
    chk(32'(extended_mode), 32'h1);
    axi_write(OFS_CTRL, 32'h3, rsp);
    chk(cal_pulses, 1);
    axi_read(OFS_STATUS, rd, rsp);
    chk(rd, 32'h2);
    axi_write(OFS_STATUS, 32'h2, rsp);
    axi_read(OFS_STATUS, rd, rsp);
    chk(rd, 32'h0);
    check_coeff();
    repeat (4) begin
      frame(1);
      check_all();
    end
    // A reset in mid-run must clear what frames and calibration left behind
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    model_clear();
    chk(32'(extended_mode), 32'h0);
    check_all();
    check_coeff();
    stop_test();
  end
endmodule
